/* verilog/smbrp_pkg.sv */
// package: constants for the synchronous muxed burst read port
package smbrp_pkg;
    // ********************************************************************
    // widths and depths
    // ********************************************************************
    localparam int unsigned DATA_W = 16;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned MEM_DEPTH = 256;
    localparam int unsigned BEAT_W = 2;
    localparam int unsigned LAT_W = 2;

    // ********************************************************************
    // burst timing, in interface clock cycles
    // ********************************************************************
    localparam logic [BEAT_W-1:0] BURST_LAST = 2'h3;  // four words a burst
    localparam logic [LAT_W-1:0] READ_LATENCY = 2'h2;
    localparam logic [LAT_W-1:0] WAIT_LOAD = READ_LATENCY - 2'h1;

    // ********************************************************************
    // reset values
    // ********************************************************************
    localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 8'h00;

    // ********************************************************************
    // read sequencer states, gray coded along the path
    // ********************************************************************
    typedef enum logic [1:0] {
        SM_IDLE  = 2'h0,
        SM_WAIT  = 2'h1,
        SM_BURST = 2'h3,
        SM_HOLD  = 2'h2
    } smbrp_state_e;
endpackage : smbrp_pkg

/* verilog/smbrp_rd_if.sv */
// interface: word lookup between the port sequencer and the word store
interface smbrp_rd_if;
    import smbrp_pkg::*;
    logic [ADDR_W-1:0] rdAddr;
    logic [DATA_W-1:0] rdWord;
    modport store (input rdAddr, output rdWord);
    modport user  (output rdAddr, input rdWord);
endinterface : smbrp_rd_if

/* verilog/smbrp_word_store.sv */
// module: word store read by the burst port, written by device logic
module smbrp_word_store
    import smbrp_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic                      wrEn,
    input  wire logic [smbrp_pkg::ADDR_W-1:0] wrAddr,
    input  wire logic [smbrp_pkg::DATA_W-1:0] wrData,
    smbrp_rd_if.store                      rd
);
    // ********************************************************************
    // storage
    // ********************************************************************
    // no reset: contents are whatever the device logic wrote last
    logic [DATA_W-1:0] mem [MEM_DEPTH];

    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    assign rd.rdWord = mem[rd.rdAddr];
endmodule : smbrp_word_store

/* verilog/smbrp_burst_read_port.sv */
// module: device side read path of the synchronous muxed burst port
// Notes on behaviour
// - device and processor sample and launch everything on one clock edge
// - burst-ready rises two cycles after read enable is seen low
// - burst-ready falls one cycle after the last burst word appears
// - first word two cycles after read enable, then one word per cycle
// - last word of the burst stays on the bus until read enable rises
// - burst-ready never falls before all words of the burst have gone
// - read latency is two cycles, fit for clocks up to 100 MHz
module smbrp_burst_read_port
    import smbrp_pkg::*;
(
    input  wire logic                         clk,
    input  wire logic                         arst_n,
    input  wire logic                         chipSelN,
    input  wire logic                         addrValidN,
    input  wire logic                         readEnN,
    input  wire logic [smbrp_pkg::DATA_W-1:0] muxedAddrDataBusIn,
    output logic      [smbrp_pkg::DATA_W-1:0] muxedAddrDataBusOut,
    output logic                              muxedAddrDataBusOe,
    output logic                              burstRdy,
    input  wire logic                         memWrEn,
    input  wire logic [smbrp_pkg::ADDR_W-1:0] memWrAddr,
    input  wire logic [smbrp_pkg::DATA_W-1:0] memWrData
);
    import smbrp_pkg::*;

    // ********************************************************************
    // helpers
    // ********************************************************************
    function automatic logic [ADDR_W-1:0] nextAddr(
        input logic [ADDR_W-1:0] a
    );
        nextAddr = a + 8'h01;
    endfunction : nextAddr

    function automatic logic lowPair(
        input logic selN,
        input logic strobeN
    );
        lowPair = ~selN & ~strobeN;
    endfunction : lowPair

    // ********************************************************************
    // word store
    // ********************************************************************
    smbrp_rd_if rdLink ();

    smbrp_word_store u_store (
        .clk    (clk),
        .wrEn   (memWrEn),
        .wrAddr (memWrAddr),
        .wrData (memWrData),
        .rd     (rdLink.store)
    );

    // ********************************************************************
    // sequencer state
    // ********************************************************************
    smbrp_state_e      state_q,   state_d;
    logic [LAT_W-1:0]  waitCnt_q, waitCnt_d;
    logic [BEAT_W-1:0] beat_q,    beat_d;

    // ********************************************************************
    // ready flag state
    // ********************************************************************
    logic              rdy_q,     rdy_d;

    // ********************************************************************
    // data path state
    // ********************************************************************
    logic [ADDR_W-1:0] addr_q,    addr_d;
    logic [DATA_W-1:0] data_q,    data_d;
    logic              busOe_q,   busOe_d;

    // ********************************************************************
    // decoded strobes
    // ********************************************************************
    logic              readSeen;
    logic              addrSeen;
    logic              latDone;
    logic              lastBeat;
    logic              wordLoad;

    assign rdLink.rdAddr = addr_q;

    // inputs come from a master on this same clock edge, so no synchroniser
    assign readSeen = lowPair(chipSelN, readEnN);
    assign addrSeen = (state_q == SM_IDLE) & lowPair(chipSelN, addrValidN);
    assign latDone  = (state_q == SM_WAIT) & (waitCnt_q == 2'h0);
    assign lastBeat = (state_q == SM_BURST) & (beat_q == BURST_LAST);
    assign wordLoad = latDone | ((state_q == SM_BURST) & ~lastBeat);

    // ********************************************************************
    // sequencer
    // ********************************************************************
    always_comb begin
        state_d   = state_q;
        waitCnt_d = waitCnt_q;
        beat_d    = beat_q;
        case (state_q)
            SM_IDLE: begin
                if (readSeen) begin
                    // one cycle latency is not offered: boot code needs two
                    waitCnt_d = WAIT_LOAD;
                    state_d   = SM_WAIT;
                end
            end
            SM_WAIT: begin
                if (latDone) begin
                    beat_d  = 2'h0;
                    state_d = SM_BURST;
                end else begin
                    waitCnt_d = waitCnt_q - 2'h1;
                end
            end
            SM_BURST: begin
                // an early release drops the remaining words, but the
                // burst still runs to its end so ready never breaks it
                if (lastBeat) begin
                    state_d = SM_HOLD;
                end else begin
                    beat_d = beat_q + 2'h1;
                end
            end
            SM_HOLD: begin
                // data_q is left untouched, so the last word stands
                if (~readSeen) begin
                    state_d = SM_IDLE;
                end
            end
            default: begin
                state_d = SM_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q   <= SM_IDLE;
            waitCnt_q <= 2'h0;
            beat_q    <= 2'h0;
        end else begin
            state_q   <= state_d;
            waitCnt_q <= waitCnt_d;
            beat_q    <= beat_d;
        end
    end

    // ********************************************************************
    // burst ready flag
    // ********************************************************************
    always_comb begin
        rdy_d = rdy_q;
        if (wordLoad) begin
            rdy_d = 1'b1;
        end else if (lastBeat | (state_q == SM_IDLE)) begin
            rdy_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdy_q <= 1'b0;
        end else begin
            rdy_q <= rdy_d;
        end
    end

    // ********************************************************************
    // word address
    // ********************************************************************
    always_comb begin
        addr_d = addr_q;
        if (addrSeen) begin
            addr_d = muxedAddrDataBusIn[ADDR_W-1:0];
        end
        if (wordLoad) begin
            addr_d = nextAddr(addr_q);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_q <= ADDR_RESET;
        end else begin
            addr_q <= addr_d;
        end
    end

    // ********************************************************************
    // read data
    // ********************************************************************
    always_comb begin
        data_d = data_q;
        if (wordLoad) begin
            data_d = rdLink.rdWord;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            data_q <= DATA_RESET;
        end else begin
            data_q <= data_d;
        end
    end

    // ********************************************************************
    // bus drive enable
    // ********************************************************************
    always_comb begin
        busOe_d = readSeen;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            busOe_q <= 1'b0;
        end else begin
            busOe_q <= busOe_d;
        end
    end

    // ********************************************************************
    // outputs, all from flops
    // ********************************************************************
    assign muxedAddrDataBusOut = data_q;
    assign muxedAddrDataBusOe  = busOe_q;
    assign burstRdy            = rdy_q;
endmodule : smbrp_burst_read_port

/* sim/smbrp_port_assertions.sv */
// checker: pin timing of the burst read port
module smbrp_port_assertions import smbrp_pkg::*; (
    input logic              clk,
    input logic              arst_n,
    input logic              chipSelN,
    input logic              readEnN,
    input logic [DATA_W-1:0] muxedAddrDataBusOut,
    input logic              muxedAddrDataBusOe,
    input logic              burstRdy
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_go; !chipSelN && !readEnN && $past(readEnN); endsequence
    property p_rise; s_go |=> !burstRdy [*2] ##1 burstRdy; endproperty
    a_rise: assert property (p_rise) else $error("rise");
    property p_len; $rose(burstRdy) |-> burstRdy [*4] ##1 !burstRdy;
    endproperty
    a_len: assert property (p_len) else $error("length");
    property p_cause; $rose(burstRdy) |-> !$past(readEnN, 3); endproperty
    a_cause: assert property (p_cause) else $error("cause");
    property p_word; $rose(muxedAddrDataBusOe) |-> !burstRdy [*2] ##1 burstRdy;
    endproperty
    a_word: assert property (p_word) else $error("word");
    property p_oe;
        muxedAddrDataBusOe == (!$past(chipSelN) && !$past(readEnN));
    endproperty
    a_oe: assert property (p_oe) else $error("drive");
    property p_hold;
        muxedAddrDataBusOe && !burstRdy && $past(muxedAddrDataBusOe)
        |-> $stable(muxedAddrDataBusOut);
    endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_gap; $fell(burstRdy) |-> !burstRdy [*3]; endproperty
    a_gap: assert property (p_gap) else $error("gap");
    property p_drop; $rose(readEnN) |=> !muxedAddrDataBusOe; endproperty
    a_drop: assert property (p_drop) else $error("release");
    c_go: cover property (s_go);
    c_cut: cover property ($rose(readEnN) && burstRdy);
    c_held: cover property ($fell(burstRdy) && muxedAddrDataBusOe);
endmodule : smbrp_port_assertions

/* sim/smbrp_proc_model.sv */
// model: processor that masters the burst read port
module smbrp_proc_model import smbrp_pkg::*; (
    input  logic              clk,
    output logic              chipSelN,
    output logic              addrValidN,
    output logic              readEnN,
    output logic [DATA_W-1:0] muxedAddrDataBusIn,
    input  logic [DATA_W-1:0] muxedAddrDataBusOut,
    input  logic              muxedAddrDataBusOe,
    input  logic              burstRdy
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [DATA_W-1:0] addrDrv = DATA_RESET;
    logic              addrOn = 1'b0;
    logic [DATA_W-1:0] words[4];
    initial {chipSelN, addrValidN, readEnN} = 3'h7;
    // released bus shows the inverse, so a stale word cannot pass
    assign muxedAddrDataBusIn = muxedAddrDataBusOe ? muxedAddrDataBusOut
                              : addrOn ? addrDrv : ~muxedAddrDataBusOut;
    // keep below four cuts the burst short on purpose
    task automatic read_burst(input logic [ADDR_W-1:0] a, input int keep,
                              input int hold);
        int n;
        n = 0;
        @(posedge clk);
        chipSelN <= 1'b0;
        addrValidN <= 1'b0;
        addrOn <= 1'b1;
        addrDrv <= {8'h00, a};
        @(posedge clk);
        addrValidN <= 1'b1;
        addrOn <= 1'b0;
        readEnN <= 1'b0;
        for (int c = 0; c < 12 && n < keep; c++) begin
            @(negedge clk);
            if (burstRdy === 1'b1) begin
                words[n] = muxedAddrDataBusOut;
                n++;
            end
        end
        repeat (hold) @(negedge clk);
        @(posedge clk);
        {chipSelN, readEnN} <= 2'h3;
    endtask : read_burst
endmodule : smbrp_proc_model

/* sim/tb.sv */
// testbench: burst reads of the port through the processor model
module tb;
    import smbrp_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, arst_n = 1'b0, memWrEn = 1'b0;
    logic [ADDR_W-1:0] memWrAddr = ADDR_RESET;
    logic [DATA_W-1:0] memWrData = DATA_RESET;
    logic chipSelN, addrValidN, readEnN, muxedAddrDataBusOe, burstRdy;
    logic [DATA_W-1:0] muxedAddrDataBusIn, muxedAddrDataBusOut;
    int error_cnt = 0, checks_done = 0;
    always #50 clk = ~clk;
    smbrp_burst_read_port dut_u (.clk, .arst_n, .chipSelN, .addrValidN,
        .readEnN, .muxedAddrDataBusIn, .muxedAddrDataBusOut,
        .muxedAddrDataBusOe, .burstRdy, .memWrEn, .memWrAddr, .memWrData);
    smbrp_proc_model proc_u (.clk, .chipSelN, .addrValidN, .readEnN,
        .muxedAddrDataBusIn, .muxedAddrDataBusOut, .muxedAddrDataBusOe,
        .burstRdy);
    function automatic logic [DATA_W-1:0] expw(input logic [ADDR_W-1:0] a);
        return {~a, a};
    endfunction : expw
    task automatic check(input logic [DATA_W-1:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic words_ok(input logic [ADDR_W-1:0] a, input int k);
        for (int i = 0; i < k; i++) check(proc_u.words[i], expw(a + 8'(i)));
    endtask : words_ok
    task automatic s_full();
        proc_u.read_burst(8'hfe, 4, 3);
        words_ok(8'hfe, 4);
        @(negedge clk);
        check(muxedAddrDataBusOut, expw(8'h01));
        check({15'h0, burstRdy}, 16'h0);
    endtask : s_full
    task automatic s_early();
        proc_u.read_burst(8'h10, 2, 0);
        words_ok(8'h10, 2);
        repeat (2) @(negedge clk);
        check({14'h0, muxedAddrDataBusOe, burstRdy}, 16'h1);
        repeat (4) @(posedge clk);
    endtask : s_early
    task automatic s_back();
        for (int b = 0; b < 2; b++) begin
            proc_u.read_burst(8'h20 + 8'(4 * b), 4, 0);
            words_ok(8'h20 + 8'(4 * b), 4);
        end
    endtask : s_back
    task automatic end_of_test();
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        for (int i = 0; i < MEM_DEPTH; i++) begin
            @(posedge clk);
            memWrEn <= 1'b1;
            memWrAddr <= 8'(i);
            memWrData <= expw(8'(i));
        end
        @(posedge clk);
        memWrEn <= 1'b0;
        s_full();
        s_early();
        s_back();
        end_of_test();
    end
    initial begin
        #100us;
        error_cnt++;
        end_of_test();
    end
endmodule : tb
bind smbrp_burst_read_port smbrp_port_assertions chk_u (.clk, .arst_n,
    .chipSelN, .readEnN, .muxedAddrDataBusOut, .muxedAddrDataBusOe,
    .burstRdy);
